// File: pkg/tcc_pkg.sv
/*
 * shared constants for the transmit chain control word: field positions,
 * power-on value, serial address code and attenuator limits.
 * assumes nothing of its surroundings; imported by the serial port and control word modules.
 */
`default_nettype none
package tcc_pkg;
    localparam int unsigned TCC_WORD_W = 32;
    // register index of the transmit chain control word
    localparam logic [2:0] TCC_REG_INDEX = 3'h1;
    // bits 0..4 carry register select (0..2) and serial address (3..4)
    localparam int unsigned TCC_ADDR_LSB = 0;
    localparam int unsigned TCC_ADDR_W = 5;
    localparam logic [4:0] TCC_ADDR_CODE = 5'h19;
    // field positions
    localparam int unsigned TCC_TX_POWER_DOWN_BIT = 5;
    localparam int unsigned TCC_ATT_LSB = 6;
    localparam int unsigned TCC_ATT_W = 7;
    localparam int unsigned TCC_PHASE_LSB = 13;
    localparam int unsigned TCC_PHASE_W = 5;
    localparam int unsigned TCC_LB_BIT = 18;
    localparam int unsigned TCC_LB_ATT_BIT = 19;
    localparam int unsigned TCC_ALARM_CLR_BIT = 20;
    localparam int unsigned TCC_REF_PD_BIT = 21;
    localparam int unsigned TCC_RSV_LSB = 22;
    localparam int unsigned TCC_RSV_W = 10;
    // value after reset: address code, tx off, attenuation 0x08, phase 1_0000
    localparam logic [31:0] TCC_RESET_WORD = 32'h0002_0239;
    // attenuator: 0.5 dB per code step, 35.5 dB at the top code
    localparam logic [6:0] TCC_ATT_MAX_CODE = 7'h47;
    localparam logic [6:0] TCC_ATT_MIN_CODE = 7'h00;
    localparam logic [4:0] TCC_PHASE_SUGGESTED = 5'h08;
    localparam int unsigned TCC_SYNC_STAGES = 2;
endpackage
`default_nettype wire

// File: pkg/tcc_ser_if.sv
/*
 * carrier between the serial port front end and the control word logic.
 * assumes both ends run on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface tcc_ser_if;
    logic [31:0] wr_word;
    logic wr_stb;
    logic [31:0] rd_word;
    // front end delivers received words, takes the word to be read back
    modport front (output wr_word, output wr_stb, input rd_word);
    modport core (input wr_word, input wr_stb, output rd_word);
endinterface
`default_nettype wire

// File: src/tcc_serial_port.sv
/*
 * serial programming port: synchronises the pin inputs, shifts a 32-bit word
 * in bit 0 first, and on the latch edge hands it over and reloads the readback.
 * assumes the serial clock is far slower than core_clk (at least 3 core cycles
 * per serial phase) and that pins are asynchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module tcc_serial_port
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // serial pins
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    output logic ser_dout,
    // towards the control word
    tcc_ser_if.front port_if
);
    logic [1:0] clk_sync_q;
    logic [1:0] dat_sync_q;
    logic [1:0] lat_sync_q;
    logic clk_prev_q;
    logic lat_prev_q;
    logic clk_rise;
    logic lat_rise;
    logic [31:0] shift_q;
    logic [31:0] rd_shift_q;
    logic wr_stb_q;
    logic [31:0] wr_word_q;
    logic dout_q;

    // two-stage synchronisers; edge detection looks only at the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_sync_q <= 2'h0;
            dat_sync_q <= 2'h0;
            lat_sync_q <= 2'h0;
            clk_prev_q <= 1'b0;
            lat_prev_q <= 1'b0;
        end else begin
            clk_sync_q <= {clk_sync_q[0], ser_clk};
            dat_sync_q <= {dat_sync_q[0], ser_data};
            lat_sync_q <= {lat_sync_q[0], ser_latch};
            clk_prev_q <= clk_sync_q[1];
            lat_prev_q <= lat_sync_q[1];
        end
    end

    assign clk_rise = clk_sync_q[1] & ~clk_prev_q;
    assign lat_rise = lat_sync_q[1] & ~lat_prev_q;

    // bit 0 arrives first, so after 32 clocks it sits at the bottom
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= 32'h0000_0000;
        end else if (clk_rise) begin
            shift_q <= {dat_sync_q[1], shift_q[31:1]};
        end
    end

    // word hand-over: a one-cycle strobe after the latch edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_stb_q <= 1'b0;
            wr_word_q <= 32'h0000_0000;
        end else begin
            wr_stb_q <= lat_rise;
            if (lat_rise) begin
                wr_word_q <= shift_q;
            end
        end
    end

    // readback: loaded on the latch edge, one bit out per serial rising edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_shift_q <= 32'h0000_0000;
            dout_q <= 1'b0;
        end else if (lat_rise) begin
            rd_shift_q <= port_if.rd_word;
            dout_q <= port_if.rd_word[0];
        end else if (clk_rise) begin
            rd_shift_q <= {1'b0, rd_shift_q[31:1]};
            dout_q <= rd_shift_q[1];
        end
    end

    assign port_if.wr_stb = wr_stb_q;
    assign port_if.wr_word = wr_word_q;
    assign ser_dout = dout_q;
endmodule
`default_nettype wire

// File: src/tcc_tx_chain_ctrl.sv
/*
 * transmit chain control word: stores the serially written word, decodes
 * its fields into registered control outputs, and keeps the power alarm.
 * assumes the alarm detector trip input is asynchronous to core_clk and
 * that the analog side reads the control outputs as static levels.
 */
// Functional notes
// [RULE1] power-down bit high switches whole tx chain off
// [RULE2] 7-bit attenuation code, 0.5 dB steps, max 0x47
// [RULE3] 5-bit phase trim corrects I/Q LO unbalance
// [RULE4] host programs phase trim to 0_1000
// [RULE5] loopback bit closes mixer-to-third-IF-stage switch
// [RULE6] loopback turns off tx amp, LNA, IF stages 1-2
// [RULE7] attenuator bit inserts fixed 20 dB in loopback
// [RULE8] writing one to clear bit releases alarm output
// [RULE9] reference buffer disabled while its bit is one
// [RULE10] host writes zero reserved bits, fixed address code
`timescale 1ns/1ps
`default_nettype none
module tcc_tx_chain_ctrl
    import tcc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // serial programming pins
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    output logic ser_dout,
    // power detector
    input wire logic power_detect_trip,
    output logic power_alarm_n,
    // transmit chain controls
    output logic tx_power_down,
    output logic [tcc_pkg::TCC_ATT_W-1:0] tx_attenuation_code,
    output logic [tcc_pkg::TCC_PHASE_W-1:0] tx_iq_phase_trim,
    output logic tx_amp_power_down,
    // loopback and receive side controls
    output logic loopback_switch_enable,
    output logic loopback_attenuator_enable,
    output logic rx_lna_power_down,
    output logic rx_if_gain_stage_first_power_down,
    output logic rx_if_gain_stage_second_power_down,
    // reference input
    output logic ref_buffer_power_down
);
    import tcc_pkg::*;

    tcc_ser_if port_if ();

    logic [31:0] ctrl_q;
    logic [1:0] trip_sync_q;
    logic alarm_q;
    logic addr_hit;
    logic clear_req;
    logic [6:0] att_field;
    logic [6:0] att_d;
    logic lb_on;

    logic tx_power_down_q;
    logic [6:0] tx_attenuation_code_q;
    logic [4:0] tx_iq_phase_trim_q;
    logic tx_amp_power_down_q;
    logic loopback_switch_enable_q;
    logic loopback_attenuator_enable_q;
    logic rx_lna_power_down_q;
    logic rx_if1_pd_q;
    logic rx_if2_pd_q;
    logic ref_buffer_power_down_q;
    logic power_alarm_n_q;

    tcc_serial_port u_port (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_latch(ser_latch),
        .ser_dout(ser_dout),
        .port_if(port_if.front)
    );

    // words for other registers share the serial lines and are ignored here
    assign addr_hit = port_if.wr_stb &&
        (port_if.wr_word[TCC_ADDR_LSB +: TCC_ADDR_W] == TCC_ADDR_CODE); // [RULE10]
    assign clear_req = addr_hit && port_if.wr_word[TCC_ALARM_CLR_BIT]; // [RULE8]

    // stored word; reserved bits are forced to zero whatever the host sends
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= TCC_RESET_WORD; // [RULE1]
        end else if (addr_hit) begin
            ctrl_q <= {{TCC_RSV_W{1'b0}}, port_if.wr_word[TCC_RSV_LSB-1:0]};
        end
    end

    // power detector trip passes two flops before anything reads it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trip_sync_q <= 2'h0;
        end else begin
            trip_sync_q <= {trip_sync_q[0], power_detect_trip};
        end
    end

    // alarm is sticky; a trip in the clearing cycle keeps it set
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_q <= 1'b0;
        end else if (trip_sync_q[1]) begin
            alarm_q <= 1'b1;
        end else if (clear_req) begin
            alarm_q <= 1'b0; // [RULE8]
        end
    end

    // codes past the top step would ask for more than the attenuator has
    assign att_field = ctrl_q[TCC_ATT_LSB +: TCC_ATT_W];
    assign att_d = (att_field > TCC_ATT_MAX_CODE) ? TCC_ATT_MAX_CODE : att_field; // [RULE2]
    assign lb_on = ctrl_q[TCC_LB_BIT];

    // registered decode, so every analog control changes on a clock edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_power_down_q <= TCC_RESET_WORD[TCC_TX_POWER_DOWN_BIT];
            tx_attenuation_code_q <= TCC_RESET_WORD[TCC_ATT_LSB +: TCC_ATT_W];
            tx_iq_phase_trim_q <= TCC_RESET_WORD[TCC_PHASE_LSB +: TCC_PHASE_W];
        end else begin
            tx_power_down_q <= ctrl_q[TCC_TX_POWER_DOWN_BIT]; // [RULE1]
            tx_attenuation_code_q <= att_d; // [RULE2]
            tx_iq_phase_trim_q <= ctrl_q[TCC_PHASE_LSB +: TCC_PHASE_W]; // [RULE3]
        end
    end

    // loopback path: the amplifiers that would fight the loop are shut off
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            loopback_switch_enable_q <= TCC_RESET_WORD[TCC_LB_BIT];
            loopback_attenuator_enable_q <= TCC_RESET_WORD[TCC_LB_ATT_BIT];
            tx_amp_power_down_q <= 1'b1;
            rx_lna_power_down_q <= 1'b0;
            rx_if1_pd_q <= 1'b0;
            rx_if2_pd_q <= 1'b0;
        end else begin
            loopback_switch_enable_q <= lb_on; // [RULE5]
            loopback_attenuator_enable_q <= ctrl_q[TCC_LB_ATT_BIT]; // [RULE7]
            tx_amp_power_down_q <= lb_on | ctrl_q[TCC_TX_POWER_DOWN_BIT]; // [RULE6]
            rx_lna_power_down_q <= lb_on; // [RULE6]
            rx_if1_pd_q <= lb_on; // [RULE6]
            rx_if2_pd_q <= lb_on; // [RULE6]
        end
    end

    // reference buffer and the active-low alarm pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_buffer_power_down_q <= TCC_RESET_WORD[TCC_REF_PD_BIT];
            power_alarm_n_q <= 1'b1;
        end else begin
            ref_buffer_power_down_q <= ctrl_q[TCC_REF_PD_BIT]; // [RULE9]
            power_alarm_n_q <= ~alarm_q; // [RULE8]
        end
    end

    // readback shows the stored word with bit 20 replaced by the live alarm
    assign port_if.rd_word = {ctrl_q[31:TCC_ALARM_CLR_BIT+1], alarm_q, ctrl_q[TCC_ALARM_CLR_BIT-1:0]};

    assign tx_power_down = tx_power_down_q;
    assign tx_attenuation_code = tx_attenuation_code_q;
    assign tx_iq_phase_trim = tx_iq_phase_trim_q;
    assign tx_amp_power_down = tx_amp_power_down_q;
    assign loopback_switch_enable = loopback_switch_enable_q;
    assign loopback_attenuator_enable = loopback_attenuator_enable_q;
    assign rx_lna_power_down = rx_lna_power_down_q;
    assign rx_if_gain_stage_first_power_down = rx_if1_pd_q;
    assign rx_if_gain_stage_second_power_down = rx_if2_pd_q;
    assign ref_buffer_power_down = ref_buffer_power_down_q;
    assign power_alarm_n = power_alarm_n_q;
endmodule
`default_nettype wire

// File: testbench/tcc_props.sv
/* assertions on the control word block's ports.
   assumes a bind onto tcc_tx_chain_ctrl, one clock. */
`timescale 1ns/1ps
`default_nettype none
module tcc_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // pins
    input wire logic ser_latch,
    input wire logic power_detect_trip,
    input wire logic power_alarm_n,
    // controls
    input wire logic tx_power_down,
    input wire logic [6:0] tx_attenuation_code,
    input wire logic [4:0] tx_iq_phase_trim,
    input wire logic tx_amp_power_down,
    input wire logic loopback_switch_enable,
    input wire logic loopback_attenuator_enable,
    input wire logic rx_lna_power_down,
    input wire logic rx_if_gain_stage_first_power_down,
    input wire logic rx_if_gain_stage_second_power_down,
    input wire logic ref_buffer_power_down
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // stored fields as one value
    wire logic [15:0] ctl = {tx_power_down, tx_attenuation_code, tx_iq_phase_trim, loopback_switch_enable,
        loopback_attenuator_enable, ref_buffer_power_down};
    // ser_latch sampled high 4 to 6 cycles back is the only legal cause of a change
    sequence latched;
        $past(ser_latch, 4) || $past(ser_latch, 5) || $past(ser_latch, 6);
    endsequence
    rx_follow_lb_a: assert property ({rx_lna_power_down, rx_if_gain_stage_first_power_down,
        rx_if_gain_stage_second_power_down} == {3{loopback_switch_enable}}) else $error("rx pd wrong");
    amp_cause_a: assert property (tx_amp_power_down == (tx_power_down | loopback_switch_enable))
        else $error("amp pd wrong");
    att_range_a: assert property (tx_attenuation_code <= 7'h47) else $error("att range");
    ctl_hold_a: assert property (!ser_latch [*8] |=> $stable(ctl)) else $error("ctl moved");
    ctl_cause_a: assert property ($changed(ctl) |-> latched) else $error("ctl timing");
    alarm_set_a: assert property (power_detect_trip [*5] |-> !power_alarm_n) else $error("no alarm");
    alarm_keep_a: assert property (!ser_latch [*8] ##0 !power_alarm_n |=> !power_alarm_n)
        else $error("alarm dropped");
    alarm_clr_a: assert property ($rose(power_alarm_n) |-> latched) else $error("alarm freed");
    // main scenarios
    cover property (loopback_switch_enable && loopback_attenuator_enable);
    cover property (tx_attenuation_code == 7'h47);
    cover property (!power_alarm_n ##1 power_alarm_n);
endmodule
`default_nettype wire

// File: testbench/tcc_host_model.sv
/* host side of the serial port: shifts words bit 0 first, gathers readback.
   assumes core_clk is the bench clock; pins change 1 ns after its edge. */
`timescale 1ns/1ps
`default_nettype none
module tcc_host_model (
    // clock
    input wire logic core_clk,
    // serial pins
    output var logic ser_clk,
    output var logic ser_data,
    output var logic ser_latch,
    input wire logic ser_dout
);
    // serial clock stands low outside frames
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_latch = 1'b0;
    end
    // four core cycles per level, one above the synchroniser's need
    task automatic step;
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    // one frame; data rests at the inverse of its last bit afterwards
    task automatic send(input logic [31:0] w, output logic [31:0] rb);
        for (int i = 0; i < 32; i++) begin
            ser_data = w[i];
            step();
            rb[i] = ser_dout;
            ser_clk = 1'b1;
            step();
            ser_clk = 1'b0;
        end
        ser_data = ~w[31];
        ser_latch = 1'b1;
        step();
        ser_latch = 1'b0;
        step();
    endtask
endmodule
`default_nettype wire

// File: testbench/tcc_tx_chain_ctrl_tb.sv
/* bench for the control word block: serial writes, trip, output checks.
   assumes the host model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tcc_tx_chain_ctrl_tb;
    import tcc_pkg::*;
    logic core_clk;
    logic rst_n;
    logic power_detect_trip;
    wire logic ser_clk, ser_data, ser_latch, ser_dout, power_alarm_n, tx_power_down, tx_amp_power_down;
    wire logic loopback_switch_enable, loopback_attenuator_enable, rx_lna_power_down, ref_buffer_power_down;
    wire logic rx_if_gain_stage_first_power_down, rx_if_gain_stage_second_power_down;
    wire logic [6:0] tx_attenuation_code;
    wire logic [4:0] tx_iq_phase_trim;
    int err_count = 0;
    int comparisons = 0;
    logic [31:0] rb;
    logic [31:0] w [5];
    tcc_tx_chain_ctrl uut (.core_clk, .rst_n, .ser_clk, .ser_data, .ser_latch, .ser_dout, .power_detect_trip,
        .power_alarm_n, .tx_power_down, .tx_attenuation_code, .tx_iq_phase_trim, .tx_amp_power_down,
        .loopback_switch_enable, .loopback_attenuator_enable, .rx_lna_power_down,
        .rx_if_gain_stage_first_power_down, .rx_if_gain_stage_second_power_down, .ref_buffer_power_down);
    tcc_host_model host (.core_clk, .ser_clk, .ser_data, .ser_latch, .ser_dout);
    // clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // outputs packed in the same order expect_of builds
    function automatic logic [31:0] status();
        return {12'h000, ref_buffer_power_down, loopback_attenuator_enable, loopback_switch_enable,
            rx_lna_power_down, rx_if_gain_stage_first_power_down, rx_if_gain_stage_second_power_down,
            tx_amp_power_down, tx_iq_phase_trim, tx_attenuation_code, tx_power_down};
    endfunction
    // codes past the top attenuation clamp to it
    function automatic logic [31:0] expect_of(input logic [31:0] v);
        logic [6:0] a;
        a = (v[12:6] > TCC_ATT_MAX_CODE) ? TCC_ATT_MAX_CODE : v[12:6];
        return {12'h000, v[21], v[19], {4{v[18]}}, v[18] | v[5], v[17:13], a, v[5]};
    endfunction
    // sw is ref pd, alarm clear, lb att, lb
    function automatic logic [31:0] mk(input logic [6:0] a, input logic [4:0] p, input logic [3:0] sw,
        input logic pd);
        return {10'h000, sw, p, a, pd, TCC_ADDR_CODE};
    endfunction
    task automatic check_reset;
        chk(status(), expect_of(mk(7'h08, 5'h10, 4'h0, 1'b1)));
        chk({31'h0, power_alarm_n}, 32'h1);
        chk({31'h0, ser_dout}, 32'h0);
    endtask
    // boundary fields; readback lags two writes
    task automatic check_fields;
        w = '{mk(7'h47, TCC_PHASE_SUGGESTED, 4'h0, 1'b0), mk(7'h00, 5'h1f, 4'h1, 1'b0),
            mk(7'h2a, 5'h15, 4'h8, 1'b1), mk(7'h7f, 5'h00, 4'h3, 1'b0),
            mk(7'h01, TCC_PHASE_SUGGESTED, 4'h0, 1'b0)};
        for (int i = 0; i < 5; i++) begin
            host.send(w[i], rb);
            tick(8);
            chk(status(), expect_of(w[i]));
            if (i >= 2) begin
                chk(rb, w[i - 2]);
            end
        end
    endtask
    // refused words carry other field values, so a wrong accept would show
    task automatic check_refused;
        host.send(w[0] ^ 32'h0000_0001, rb);
        host.send(w[3] ^ 32'h0000_0010, rb);
        tick(8);
        chk(status(), expect_of(w[4]));
        chk(rb, w[4]);
    endtask
    task automatic check_alarm;
        power_detect_trip = 1'b1;
        tick(6);
        power_detect_trip = 1'b0;
        chk({31'h0, power_alarm_n}, 32'h0);
        host.send(w[4], rb);
        tick(8);
        chk({31'h0, power_alarm_n}, 32'h0);
        host.send(w[4] | 32'h0010_0000, rb);
        tick(8);
        chk(rb, w[4] | 32'h0010_0000);
        chk({31'h0, power_alarm_n}, 32'h1);
    endtask
    // reset in mid-run must bring back the power-on controls
    task automatic check_mid_reset;
        rst_n = 1'b0;
        tick(3);
        rst_n = 1'b1;
        tick(2);
        check_reset();
    endtask
    task automatic summarize;
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        #100us;
        err_count++;
        summarize();
    end
    initial begin
        rst_n = 1'b0;
        power_detect_trip = 1'b0;
        tick(20);
        rst_n = 1'b1;
        tick(2);
        check_reset();
        check_fields();
        check_refused();
        check_alarm();
        check_mid_reset();
        summarize();
    end
endmodule
bind tcc_tx_chain_ctrl tcc_props chk (.core_clk, .rst_n, .ser_latch, .power_detect_trip, .power_alarm_n,
    .tx_power_down, .tx_attenuation_code, .tx_iq_phase_trim, .tx_amp_power_down, .loopback_switch_enable,
    .loopback_attenuator_enable, .rx_lna_power_down, .rx_if_gain_stage_first_power_down,
    .rx_if_gain_stage_second_power_down, .ref_buffer_power_down);
`default_nettype wire
